// ---- rtl/valve_cfg_pkg.sv ----
`default_nettype none
package valve_cfg_pkg;
  // ****************************************
  // Encodings and widths
  // ****************************************
  localparam int POS_W = 12;            // Position in tenths of a degree
  localparam int CMD_W = 16;            // Command current in microamps
  localparam int IDX_N = 10;
  localparam logic [CMD_W-1:0] LOSS_THRESH_UA = 16'h0032; // 0.05 mA
  localparam logic [2:0] LOSS_CFG_MAX = 3'h4;
  localparam logic [2:0] LOSS_CFG_HOLD = 3'h4;
  localparam logic [2:0] LOSS_CFG_RESET = 3'h4;
  localparam logic [2:0] STBY_CFG_MAX = 3'h3;
  localparam logic [2:0] STBY_CFG_RESET = 3'h0;
  localparam logic [2:0] DB_CFG_MAX = 3'h5;
  localparam logic [2:0] DB_CFG_RESET = 3'h2;
  localparam logic [POS_W-1:0] HI_LIMIT_RESET = 12'h320;  // 80.0 deg
  localparam logic [POS_W-1:0] HI_LIMIT_OFFSET = 12'h00a; // 1.0 deg
  localparam logic [POS_W-1:0] HI_STEP = 12'h00a;         // 1.0 deg
  localparam logic [POS_W-1:0] POS_MAX = 12'hfff;
  // Deadband in hundredths of a percent of command span
  localparam logic [7:0] DB_0 = 8'h00;
  localparam logic [7:0] DB_1 = 8'h03;
  localparam logic [7:0] DB_2 = 8'h06;
  localparam logic [7:0] DB_3 = 8'h0d;
  localparam logic [7:0] DB_4 = 8'h10;
  localparam logic [7:0] DB_5 = 8'h13;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 50000000;
  localparam int BLANK_MS = 500;
  localparam int REPEAT_MS = 250;
  localparam int BLANK_CYC = BLANK_MS * (CLK_HZ / 1000);
  localparam int REPEAT_CYC = REPEAT_MS * (CLK_HZ / 1000);
  localparam int TMR_W = 26;
  // ****************************************
  // Command selector
  // ****************************************
  localparam logic [2:0] CMD_NONE = 3'h0;
  localparam logic [2:0] CMD_LOSS = 3'h1;
  localparam logic [2:0] CMD_STBY = 3'h2;
  localparam logic [2:0] CMD_DB = 3'h3;
  localparam logic [2:0] CMD_HI = 3'h4;
endpackage
`default_nettype wire

// ---- rtl/step_repeat.sv ----
`timescale 1ns/1ps
`default_nettype none
module step_repeat #(
  parameter int REPEAT_CYC = valve_cfg_pkg::REPEAT_CYC
) (
  input wire logic clk,          // Core clock
  input wire logic rst_n,        // Synchronised reset
  input wire logic up,           // Switch held up
  input wire logic down,         // Switch held down
  output logic step_up,          // Step pulse up
  output logic step_dn           // Step pulse down
);
  logic [valve_cfg_pkg::TMR_W-1:0] cnt_reg;
  logic held_reg;
  wire held = up ^ down;
  wire fire = held && (!held_reg || cnt_reg == valve_cfg_pkg::TMR_W'(REPEAT_CYC - 1));
  // Held switch repeats at a fixed interval
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      held_reg <= 1'b0;
      step_up <= 1'b0;
      step_dn <= 1'b0;
    end else begin
      held_reg <= held;
      cnt_reg <= (!held || fire) ? '0 : cnt_reg + 1'b1;
      step_up <= fire && up;
      step_dn <= fire && down;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/valve_config_command_handler.sv ----
// Overview of operation
// - Command below 0.05 mA means signal loss
// - Loss values 0-3 pick indexes 0,3,6,9
// - Loss value 4 holds position; default
// - Lights show value; step, Enter stores
// - Standby values 0-3 pick indexes 0,3,6,9
// - Standby switch drives standby position
// - Deadband values 0-5 map to percentages
// - Deadband default is value 2
// - High relay on when position at/above limit
// - Limit default 80.0; tracks maximum minus 1.0
// - Limit setup only in manual mode
// - Enter in adjust drives valve to limit
// - Steps of 1.0 degree, repeating when held
// - Enter stores limit; lights blank briefly
`timescale 1ns/1ps
`default_nettype none
module valve_config_command_handler #(
  parameter int BLANK_CYC = valve_cfg_pkg::BLANK_CYC,
  parameter int REPEAT_CYC = valve_cfg_pkg::REPEAT_CYC
) (
  input wire logic CORE_CLK,                                // 50 MHz clock
  input wire logic RSTN,                                    // Async reset, low
  input wire logic [2:0] CMD_SELECT,                        // Command being entered
  input wire logic CMD_START,                               // Command entry pulse
  input wire logic ENTER,                                   // Enter button level
  input wire logic STEP_UP,                                 // Step switch up
  input wire logic STEP_DOWN,                               // Step switch down
  input wire logic MANUAL_MODE,                             // Unit in manual mode
  input wire logic STANDBY_SWITCH,                          // Mode switch down
  input wire logic ADJUST_POSITION,                         // Mode switch middle
  input wire logic [valve_cfg_pkg::CMD_W-1:0] CMD_CURRENT_UA, // 4-20 mA command
  input wire logic [valve_cfg_pkg::POS_W-1:0] CMD_POSITION,   // Position from command
  input wire logic [valve_cfg_pkg::POS_W-1:0] VALVE_POSITION, // Measured position
  input wire logic [valve_cfg_pkg::POS_W-1:0] IDX0_POS,       // Stored index 0
  input wire logic [valve_cfg_pkg::POS_W-1:0] IDX3_POS,       // Stored index 3
  input wire logic [valve_cfg_pkg::POS_W-1:0] IDX6_POS,       // Stored index 6
  input wire logic [valve_cfg_pkg::POS_W-1:0] IDX9_POS,       // Stored index 9 (max)
  input wire logic MAX_POS_WRITE,                           // Maximum modified pulse
  output logic [valve_cfg_pkg::POS_W-1:0] SETPOINT,         // Actuator setpoint
  output logic [valve_cfg_pkg::IDX_N-1:0] NUM_LIGHTS,       // Numbered lights
  output logic SET_B_LIGHT,                                 // Command set light
  output logic SIGNAL_LOSS,                                 // Loss of signal flag
  output logic HIGH_LIMIT_RELAY_OUTPUT,                     // Relay driver 3
  output logic [7:0] DEADBAND,                              // Deadband, 0.01 %
  output logic [2:0] LOSS_CFG,                              // Stored loss value
  output logic [2:0] STBY_CFG,                              // Stored standby value
  output logic [2:0] DB_CFG,                                // Stored deadband value
  output logic [valve_cfg_pkg::POS_W-1:0] HI_LIMIT          // Stored threshold
);
  localparam int PW = valve_cfg_pkg::POS_W;

  // ****************************************
  // Reset synchroniser
  // ****************************************
  logic rst_meta_reg, rst_n;
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [PW-1:0] idx_pos(input logic [2:0] sel,
      input logic [PW-1:0] p0, input logic [PW-1:0] p3,
      input logic [PW-1:0] p6, input logic [PW-1:0] p9);
    logic [PW-1:0] r;
    r = p0;
    unique case (sel)
      3'h0: r = p0;
      3'h1: r = p3;
      3'h2: r = p6;
      default: r = p9;
    endcase
    return r;
  endfunction

  function automatic logic [7:0] db_value(input logic [2:0] sel);
    logic [7:0] r;
    r = valve_cfg_pkg::DB_0;
    unique case (sel)
      3'h0: r = valve_cfg_pkg::DB_0;
      3'h1: r = valve_cfg_pkg::DB_1;
      3'h2: r = valve_cfg_pkg::DB_2;
      3'h3: r = valve_cfg_pkg::DB_3;
      3'h4: r = valve_cfg_pkg::DB_4;
      default: r = valve_cfg_pkg::DB_5;
    endcase
    return r;
  endfunction

  // ****************************************
  // Step switch and enter edge
  // ****************************************
  logic step_up_p, step_dn_p, enter_d_reg;
  step_repeat #(.REPEAT_CYC(REPEAT_CYC)) u_step (
    .clk(CORE_CLK),
    .rst_n(rst_n),
    .up(STEP_UP),
    .down(STEP_DOWN),
    .step_up(step_up_p),
    .step_dn(step_dn_p)
  );
  wire enter_p = ENTER && !enter_d_reg;

  // ****************************************
  // Command state machine
  // ****************************************
  typedef enum logic [2:0] {IDLE, SEL_EDIT, HI_ARM, HI_EDIT} state_e;
  state_e state_reg, state_next;
  logic [2:0] cmd_reg, edit_reg;
  logic [PW-1:0] hi_edit_reg, hold_pos_reg;
  logic [valve_cfg_pkg::TMR_W-1:0] blank_reg;

  wire is_sel_cmd = CMD_SELECT == valve_cfg_pkg::CMD_LOSS ||
                    CMD_SELECT == valve_cfg_pkg::CMD_STBY ||
                    CMD_SELECT == valve_cfg_pkg::CMD_DB;
  wire hi_ok = CMD_SELECT == valve_cfg_pkg::CMD_HI && MANUAL_MODE;
  wire [2:0] edit_max = (cmd_reg == valve_cfg_pkg::CMD_LOSS) ? valve_cfg_pkg::LOSS_CFG_MAX :
                        (cmd_reg == valve_cfg_pkg::CMD_STBY) ? valve_cfg_pkg::STBY_CFG_MAX :
                        valve_cfg_pkg::DB_CFG_MAX;
  wire sel_store = state_reg == SEL_EDIT && enter_p;
  wire hi_arm_go = state_reg == HI_ARM && enter_p && ADJUST_POSITION;
  wire hi_store = state_reg == HI_EDIT && enter_p;
  wire [PW:0] hi_up = {1'b0, hi_edit_reg} + {1'b0, valve_cfg_pkg::HI_STEP};
  wire [PW-1:0] hi_up_sat = hi_up[PW] ? valve_cfg_pkg::POS_MAX : hi_up[PW-1:0];
  wire [PW-1:0] hi_dn_sat = (hi_edit_reg < valve_cfg_pkg::HI_STEP) ? '0 :
                            hi_edit_reg - valve_cfg_pkg::HI_STEP;
  wire [PW-1:0] max_minus = (IDX9_POS < valve_cfg_pkg::HI_LIMIT_OFFSET) ? '0 :
                            IDX9_POS - valve_cfg_pkg::HI_LIMIT_OFFSET;
  wire loss = CMD_CURRENT_UA < valve_cfg_pkg::LOSS_THRESH_UA;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      IDLE: begin
        if (CMD_START && is_sel_cmd) state_next = SEL_EDIT;
        else if (CMD_START && hi_ok) state_next = HI_ARM;
      end
      SEL_EDIT: if (enter_p) state_next = IDLE;
      HI_ARM: begin
        if (!MANUAL_MODE) state_next = IDLE;
        else if (hi_arm_go) state_next = HI_EDIT;
      end
      HI_EDIT: begin
        if (!MANUAL_MODE || enter_p) state_next = IDLE;
      end
      default: state_next = IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= IDLE;
      enter_d_reg <= 1'b0;
      cmd_reg <= valve_cfg_pkg::CMD_NONE;
    end else begin
      state_reg <= state_next;
      enter_d_reg <= ENTER;
      if (state_reg == IDLE && CMD_START) cmd_reg <= CMD_SELECT;
    end
  end

  // Editing value for selection commands
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      edit_reg <= 3'h0;
    end else if (state_reg == IDLE && CMD_START) begin
      edit_reg <= (CMD_SELECT == valve_cfg_pkg::CMD_LOSS) ? LOSS_CFG :
                  (CMD_SELECT == valve_cfg_pkg::CMD_STBY) ? STBY_CFG : DB_CFG;
    end else if (state_reg == SEL_EDIT) begin
      if (step_up_p && edit_reg < edit_max) edit_reg <= edit_reg + 3'h1;
      else if (step_dn_p && edit_reg != 3'h0) edit_reg <= edit_reg - 3'h1;
    end
  end

  // Stored configuration
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      LOSS_CFG <= valve_cfg_pkg::LOSS_CFG_RESET;
      STBY_CFG <= valve_cfg_pkg::STBY_CFG_RESET;
      DB_CFG <= valve_cfg_pkg::DB_CFG_RESET;
      HI_LIMIT <= valve_cfg_pkg::HI_LIMIT_RESET;
    end else begin
      if (sel_store && cmd_reg == valve_cfg_pkg::CMD_LOSS) LOSS_CFG <= edit_reg;
      if (sel_store && cmd_reg == valve_cfg_pkg::CMD_STBY) STBY_CFG <= edit_reg;
      if (sel_store && cmd_reg == valve_cfg_pkg::CMD_DB) DB_CFG <= edit_reg;
      if (hi_store) HI_LIMIT <= hi_edit_reg;
      else if (MAX_POS_WRITE) HI_LIMIT <= max_minus;
    end
  end

  // Threshold adjustment and blanking
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      hi_edit_reg <= valve_cfg_pkg::HI_LIMIT_RESET;
      blank_reg <= '0;
    end else begin
      if (hi_arm_go) hi_edit_reg <= HI_LIMIT;
      else if (state_reg == HI_EDIT && step_up_p) hi_edit_reg <= hi_up_sat;
      else if (state_reg == HI_EDIT && step_dn_p) hi_edit_reg <= hi_dn_sat;
      if (hi_store) blank_reg <= valve_cfg_pkg::TMR_W'(BLANK_CYC);
      else if (blank_reg != '0) blank_reg <= blank_reg - 1'b1;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  wire in_hi = state_reg == HI_EDIT;
  wire [PW-1:0] normal_sp = !loss ? CMD_POSITION :
      (LOSS_CFG == valve_cfg_pkg::LOSS_CFG_HOLD) ? hold_pos_reg :
      idx_pos(LOSS_CFG, IDX0_POS, IDX3_POS, IDX6_POS, IDX9_POS);
  wire [PW-1:0] sp_next = STANDBY_SWITCH ?
      idx_pos(STBY_CFG, IDX0_POS, IDX3_POS, IDX6_POS, IDX9_POS) :
      in_hi ? hi_edit_reg : normal_sp;
  wire [valve_cfg_pkg::IDX_N-1:0] lights_next =
      (blank_reg != '0) ? '0 :
      (state_reg == SEL_EDIT) ? valve_cfg_pkg::IDX_N'(1) << edit_reg : '0;

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      hold_pos_reg <= '0;
      SETPOINT <= '0;
      NUM_LIGHTS <= '0;
      SET_B_LIGHT <= 1'b0;
      SIGNAL_LOSS <= 1'b0;
      HIGH_LIMIT_RELAY_OUTPUT <= 1'b0;
      DEADBAND <= valve_cfg_pkg::DB_2;
    end else begin
      if (!loss) hold_pos_reg <= CMD_POSITION;
      SETPOINT <= sp_next;
      NUM_LIGHTS <= lights_next;
      SET_B_LIGHT <= (state_reg != IDLE) && (blank_reg == '0);
      SIGNAL_LOSS <= loss;
      HIGH_LIMIT_RELAY_OUTPUT <= VALVE_POSITION >= HI_LIMIT;
      DEADBAND <= db_value(DB_CFG);
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence store_seq;
    state_reg == HI_EDIT && enter_p;
  endsequence
  relay_follows_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    ##1 (HIGH_LIMIT_RELAY_OUTPUT == ($past(VALVE_POSITION) >= $past(HI_LIMIT))))
    else $error("High limit relay wrong");
  loss_flag_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    (CMD_CURRENT_UA < 16'h0032) |=> SIGNAL_LOSS)
    else $error("Loss not flagged");
  standby_drive_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    (STANDBY_SWITCH && STBY_CFG == 3'h3) |=> SETPOINT == $past(IDX9_POS))
    else $error("Standby setpoint wrong");
  hi_manual_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    (state_reg == IDLE && state_next == HI_ARM) |-> MANUAL_MODE)
    else $error("Limit setup outside manual");
  store_blank_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    store_seq |=> (HI_LIMIT == $past(hi_edit_reg)) ##1 (NUM_LIGHTS == '0 && !SET_B_LIGHT))
    else $error("Store or blank missing");
  db_range_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    DB_CFG <= 3'h5)
    else $error("Deadband out of range");
  hi_step_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    (in_hi && step_up_p && hi_edit_reg < 12'hff6 && !enter_p) |=>
      hi_edit_reg == $past(hi_edit_reg) + 12'h00a)
    else $error("Step not 1.0 degree");
  max_track_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    (MAX_POS_WRITE && !hi_store && IDX9_POS >= 12'h00a) |=>
      HI_LIMIT == $past(IDX9_POS) - 12'h00a)
    else $error("Limit not tracking maximum");
endmodule
`default_nettype wire

// ---- testbench/valve_actuator_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module valve_actuator_model (
  input wire logic clk, // Core clock
  input wire logic [valve_cfg_pkg::POS_W-1:0] setpoint, // Demanded position
  output logic [valve_cfg_pkg::POS_W-1:0] position // Reported position
);
  // ****************************************
  // Stiff actuator, one cycle travel
  // ****************************************
  always_ff @(posedge clk) begin
    position <= setpoint;
  end
endmodule
`default_nettype wire

// ---- testbench/test_valve_config_command_handler.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_valve_config_command_handler;
  localparam int BLANK = 20;
  localparam int RPT = 10;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] sel = 3'h0;
  logic start = 1'b0;
  logic ent = 1'b0;
  logic up = 1'b0;
  logic dn = 1'b0;
  logic man = 1'b0;
  logic sb = 1'b0;
  logic mid_sw = 1'b0;
  logic mpw = 1'b0;
  logic [15:0] ua = 16'h2ee0;
  logic [11:0] cpos = 12'h100;
  logic [11:0] ip [4] = '{12'h050, 12'h1f4, 12'h2bc, 12'h384};
  logic [11:0] sp, vpos, hi;
  logic [9:0] lights;
  logic setb, loss, relay;
  logic [7:0] db;
  logic [2:0] lcfg, scfg, dcfg;
  logic [7:0] db_tab [6] = '{8'h00, 8'h03, 8'h06, 8'h0d, 8'h10, 8'h13};
  int cur_v [4] = '{0, 4, 0, 2};
  int max_v [4] = '{0, 4, 3, 5};
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;

  valve_config_command_handler #(.BLANK_CYC(BLANK), .REPEAT_CYC(RPT))
    valve_config_command_handler_inst (
    .CORE_CLK(clk), .RSTN(rstn), .CMD_SELECT(sel), .CMD_START(start),
    .ENTER(ent), .STEP_UP(up), .STEP_DOWN(dn), .MANUAL_MODE(man),
    .STANDBY_SWITCH(sb), .ADJUST_POSITION(mid_sw), .CMD_CURRENT_UA(ua),
    .CMD_POSITION(cpos), .VALVE_POSITION(vpos), .IDX0_POS(ip[0]),
    .IDX3_POS(ip[1]), .IDX6_POS(ip[2]), .IDX9_POS(ip[3]),
    .MAX_POS_WRITE(mpw), .SETPOINT(sp), .NUM_LIGHTS(lights),
    .SET_B_LIGHT(setb), .SIGNAL_LOSS(loss), .HIGH_LIMIT_RELAY_OUTPUT(relay),
    .DEADBAND(db), .LOSS_CFG(lcfg), .STBY_CFG(scfg), .DB_CFG(dcfg),
    .HI_LIMIT(hi));

  valve_actuator_model valve_actuator_model_inst (
    .clk(clk), .setpoint(sp), .position(vpos));

  initial begin
    forever #10 clk = ~clk;
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("compares %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic step(input logic is_up);
    up = is_up;
    dn = ~is_up;
    tick(1);
    up = 1'b0;
    dn = 1'b0;
    tick(4);
  endtask

  task automatic press_enter();
    ent = 1'b1;
    tick(1);
    ent = 1'b0;
    tick(3);
  endtask

  task automatic begin_cmd(input logic [2:0] c);
    sel = c;
    start = 1'b1;
    tick(1);
    start = 1'b0;
    tick(3);
  endtask

  // Walk value down to zero, then up to v, then store
  task automatic set_cfg(input logic [2:0] c, input int v);
    int vs;
    vs = (v > max_v[c]) ? max_v[c] : v;
    begin_cmd(c);
    chk("lights", {6'h00, lights}, 16'h0001 << cur_v[c]);
    repeat (cur_v[c] + 1) step(1'b0);
    repeat (v) step(1'b1);
    chk("lights", {6'h00, lights}, 16'h0001 << vs);
    press_enter();
    cur_v[c] = vs;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc >= 20000) begin
      err_total++;
      stop_test();
    end
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    tick(16);
    rstn = 1'b1;
    tick(4);
    chk("loss_cfg", {13'h0, lcfg}, 16'h0004);
    chk("db_cfg", {13'h0, dcfg}, 16'h0002);
    chk("deadband", {8'h00, db}, 16'h0006);
    chk("hi_limit", {4'h0, hi}, 16'h0320);
    chk("setpoint", {4'h0, sp}, 16'h0100);
    $display("test reset done");
    for (int v = 0; v < 6; v++) begin
      set_cfg(3'h3, v);
      chk("db_cfg", {13'h0, dcfg}, v[15:0]);
      chk("deadband", {8'h00, db}, {8'h00, db_tab[v]});
    end
    set_cfg(3'h3, 6);
    chk("db_sat", {13'h0, dcfg}, 16'h0005);
    $display("test deadband done");
    for (int v = 0; v < 4; v++) begin
      set_cfg(3'h1, v);
      ua = 16'h0031;
      tick(3);
      chk("loss", {15'h0, loss}, 16'h0001);
      chk("loss_pos", {4'h0, sp}, {4'h0, ip[v]});
      ua = 16'h0032;
      tick(3);
      chk("loss", {15'h0, loss}, 16'h0000);
    end
    set_cfg(3'h1, 4);
    cpos = 12'h111;
    tick(3);
    ua = 16'h0000;
    cpos = 12'h222;
    tick(3);
    chk("hold_pos", {4'h0, sp}, 16'h0111);
    ua = 16'h2ee0;
    tick(3);
    chk("setpoint", {4'h0, sp}, 16'h0222);
    $display("test loss done");
    for (int v = 0; v < 4; v++) begin
      set_cfg(3'h2, v);
      chk("stby_cfg", {13'h0, scfg}, v[15:0]);
      sb = 1'b1;
      tick(3);
      chk("stby_pos", {4'h0, sp}, {4'h0, ip[v]});
      sb = 1'b0;
      tick(3);
    end
    $display("test standby done");
    ip[3] = 12'h3e8;
    mpw = 1'b1;
    tick(1);
    mpw = 1'b0;
    tick(3);
    chk("hi_track", {4'h0, hi}, 16'h03de);
    mid_sw = 1'b1;
    begin_cmd(3'h4);
    chk("no_manual", {5'h00, setb, lights}, 16'h0000);
    press_enter();
    chk("no_manual_sp", {4'h0, sp}, 16'h0222);
    man = 1'b1;
    begin_cmd(3'h4);
    press_enter();
    chk("drive_hi", {4'h0, sp}, 16'h03de);
    up = 1'b1;
    tick(RPT + 5);
    up = 1'b0;
    tick(4);
    chk("stepped", {4'h0, sp}, 16'h03f2);
    chk("set_b", {15'h0, setb}, 16'h0001);
    ent = 1'b1;
    tick(1);
    ent = 1'b0;
    tick(2);
    chk("hi_store", {4'h0, hi}, 16'h03f2);
    begin_cmd(3'h3);
    chk("blank", {5'h00, setb, lights}, 16'h0000);
    tick(BLANK + 5);
    chk("unblank", {5'h00, setb, lights}, 16'h0400 | (16'h0001 << cur_v[3]));
    press_enter();
    mid_sw = 1'b0;
    man = 1'b0;
    tick(5);
    $display("test high limit done");
    cpos = 12'h3f1;
    tick(5);
    chk("relay", {15'h0, relay}, 16'h0000);
    cpos = 12'h3f2;
    tick(5);
    chk("relay", {15'h0, relay}, 16'h0001);
    $display("test relay done");
    stop_test();
  end
endmodule
`default_nettype wire
